// [hdl/bcsf_pkg.sv]
// Shared constants for the buck channel sequencer
package bcsf_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned FAULT_PULSES  = 16;
  localparam logic [4:0]  FAULT_LIMIT   = 5'h10;
  localparam int unsigned FSW_DIV_DEF   = 500;
  localparam int unsigned FAST_RATIO    = 4;
  localparam int unsigned BOOST_PERIODS = 1;
  localparam int unsigned ONTIME_DEF    = 40;
  typedef enum logic [2:0] {
    BCSF_OFF     = 3'b000,
    BCSF_DISCH   = 3'b001,
    BCSF_SOFT    = 3'b010,
    BCSF_RUN     = 3'b011,
    BCSF_STOP    = 3'b100,
    BCSF_LATCHED = 3'b101
  } bcsf_state_t;
endpackage

// [hdl/bcsf_channel.sv]
// Per-channel sequencing, clocking, boost, current limit and latch-off logic
module bcsf_channel #(
  parameter int unsigned FSW_DIV = bcsf_pkg::FSW_DIV_DEF, // mclk cycles per normal period
  parameter int unsigned ON_TIME = bcsf_pkg::ONTIME_DEF   // high-side on cycles
) (
  input  wire logic mclk_i,             // 100 MHz clock
  input  wire logic rst_i,              // Sync reset, also power-on
  input  wire logic channel_enable_i,   // Channel enable
  input  wire logic supply_ok_i,        // Both lockout monitors in range
  input  wire logic out_low_i,          // Output below 0.3 V
  input  wire logic comp_over_thr_i,    // Error output above boost threshold
  input  wire logic boost_thr_pin_hi_i, // Threshold pin high or floating
  input  wire logic skip_select_n_i,    // High enables pulse skipping
  input  wire logic skip_demand_i,      // Feedback below droop reference
  input  wire logic ind_negative_i,     // Inductor current going negative
  input  wire logic current_limit_i,    // Sensed current above limit
  input  wire logic ss_done_i,          // Soft-start ramp complete
  input  wire logic uv_fault_i,         // Output undervoltage fault
  output logic      hs_gate_o,          // High-side drive
  output logic      ls_gate_o,          // Low-side drive
  output logic      gate_float_o,       // Both drives floating
  output logic      discharge_o,        // Discharge switch closed
  output logic      soft_start_o,       // Soft-start ramp running
  output logic      transient_boost_o,  // Boost active
  output logic      fault_latched_o     // Fault latch
);
  localparam int unsigned FAST_DIV = FSW_DIV / bcsf_pkg::FAST_RATIO;
  localparam int unsigned HALF_FAST = FAST_DIV / 2;
  localparam int unsigned BOOST_LEN = FSW_DIV * bcsf_pkg::BOOST_PERIODS;

  typedef struct packed {
    bcsf_pkg::bcsf_state_t st;
    logic [15:0] nrm_cnt;
    logic [15:0] fst_cnt;
    logic [15:0] on_cnt;
    logic [15:0] bst_cnt;
    logic [4:0]  flt_cnt;
    logic        en_prev;
    logic        hs;
    logic        ls;
    logic        boost;
    logic        limited;
    logic        skip_pend;
  } bcsf_regs_t;

  bcsf_regs_t q;
  bcsf_regs_t d;

  logic nrm_tick;
  logic fst_tick;
  logic half_tick;
  logic en_rise;
  logic en_fall;
  logic skipping;
  logic switching;
  logic start_pulse;

  always_comb begin
    d = q;
    nrm_tick = (q.nrm_cnt == 16'(FSW_DIV - 1));
    fst_tick = (q.fst_cnt == 16'(FAST_DIV - 1));
    half_tick = fst_tick || (q.fst_cnt == 16'(HALF_FAST - 1));
    en_rise = channel_enable_i && !q.en_prev;
    en_fall = !channel_enable_i && q.en_prev;
    switching = (q.st == bcsf_pkg::BCSF_SOFT) || (q.st == bcsf_pkg::BCSF_RUN);
    skipping = (q.st == bcsf_pkg::BCSF_RUN) && skip_select_n_i && ind_negative_i;
    start_pulse = 1'b0;
    d.en_prev = channel_enable_i;
    d.nrm_cnt = nrm_tick ? 16'h0000 : q.nrm_cnt + 16'h0001;
    d.fst_cnt = fst_tick ? 16'h0000 : q.fst_cnt + 16'h0001;
    // Boost: fast clock for one normal period
    if (q.boost) begin
      d.bst_cnt = q.bst_cnt + 16'h0001;
      if (q.bst_cnt == 16'(BOOST_LEN - 1)) begin
        d.boost = 1'b0;
      end
    end else if (q.st == bcsf_pkg::BCSF_RUN && !skipping && comp_over_thr_i
                 && !boost_thr_pin_hi_i) begin
      d.boost = 1'b1;
      d.bst_cnt = 16'h0000;
    end
    if (!switching) begin
      d.boost = 1'b0;
    end
    // Pulse timing
    if (skipping) begin
      if (skip_demand_i) begin
        d.skip_pend = 1'b1;
      end
      start_pulse = q.skip_pend && half_tick && !q.hs;
      if (start_pulse) begin
        d.skip_pend = 1'b0;
      end
    end else begin
      d.skip_pend = 1'b0;
      start_pulse = switching && (q.boost ? fst_tick : nrm_tick);
    end
    if (start_pulse) begin
      d.on_cnt = 16'h0000;
      d.limited = 1'b0;
      d.hs = !current_limit_i;
    end else if (q.hs) begin
      d.on_cnt = q.on_cnt + 16'h0001;
      if (current_limit_i) begin
        d.hs = 1'b0;
        d.limited = 1'b1;
      end else if (q.on_cnt == 16'(ON_TIME - 1)) begin
        d.hs = 1'b0;
      end
    end
    if (!switching) begin
      d.hs = 1'b0;
    end
    d.ls = switching && !d.hs && !(skipping && ind_negative_i);
    // Fault timer on consecutive normal clocks
    if (q.st == bcsf_pkg::BCSF_RUN || q.st == bcsf_pkg::BCSF_SOFT) begin
      if (!current_limit_i && !q.limited) begin
        d.flt_cnt = 5'h00;
      end else if (nrm_tick) begin
        d.flt_cnt = q.flt_cnt + 5'h01;
      end
    end else if (q.st != bcsf_pkg::BCSF_LATCHED) begin
      d.flt_cnt = 5'h00;
    end
    unique case (q.st)
      bcsf_pkg::BCSF_OFF: begin
        if (en_rise && supply_ok_i) begin
          d.st = out_low_i ? bcsf_pkg::BCSF_SOFT : bcsf_pkg::BCSF_DISCH;
        end
      end
      bcsf_pkg::BCSF_DISCH: begin
        if (!channel_enable_i) begin
          d.st = bcsf_pkg::BCSF_STOP;
        end else if (out_low_i && supply_ok_i) begin
          d.st = bcsf_pkg::BCSF_SOFT;
        end
      end
      bcsf_pkg::BCSF_SOFT, bcsf_pkg::BCSF_RUN: begin
        if (d.flt_cnt == bcsf_pkg::FAULT_LIMIT) begin
          d.st = bcsf_pkg::BCSF_LATCHED;
        end else if (!channel_enable_i || uv_fault_i || !supply_ok_i) begin
          d.st = bcsf_pkg::BCSF_STOP;
        end else if (q.st == bcsf_pkg::BCSF_SOFT && ss_done_i) begin
          d.st = bcsf_pkg::BCSF_RUN;
        end
      end
      bcsf_pkg::BCSF_STOP: begin
        if (out_low_i) begin
          d.st = bcsf_pkg::BCSF_OFF;
        end
      end
      bcsf_pkg::BCSF_LATCHED: begin
        if (en_rise || en_fall) begin
          d.st = bcsf_pkg::BCSF_STOP;
          d.flt_cnt = 5'h00;
        end
      end
      default: d.st = bcsf_pkg::BCSF_OFF;
    endcase
    // Gates and boost never survive a step out of switching
    if (d.st != bcsf_pkg::BCSF_SOFT && d.st != bcsf_pkg::BCSF_RUN) begin
      d.hs = 1'b0;
      d.ls = 1'b0;
      d.boost = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hs_gate_o = q.hs;
  assign ls_gate_o = q.ls;
  assign gate_float_o = (q.st == bcsf_pkg::BCSF_LATCHED);
  assign discharge_o = (q.st == bcsf_pkg::BCSF_STOP) || (q.st == bcsf_pkg::BCSF_DISCH) ||
                       (q.st == bcsf_pkg::BCSF_LATCHED && !out_low_i);
  assign soft_start_o = (q.st == bcsf_pkg::BCSF_SOFT);
  assign transient_boost_o = q.boost;
  assign fault_latched_o = (q.st == bcsf_pkg::BCSF_LATCHED);

  sequence oc_run_s;
    current_limit_i && q.hs;
  endsequence

  sequence skip_due_s;
    skipping && q.skip_pend && half_tick && !q.hs;
  endsequence

  float_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    gate_float_o |-> !hs_gate_o && !ls_gate_o && !transient_boost_o)
    else $error("gates driven while latched");
  limit_cut_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    oc_run_s and !start_pulse |=> !hs_gate_o)
    else $error("high side not cut on limit");
  boost_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    boost_thr_pin_hi_i && !transient_boost_o |=> !transient_boost_o)
    else $error("boost rose while disabled");
  boost_rise_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.st == bcsf_pkg::BCSF_RUN && !skipping && comp_over_thr_i && !boost_thr_pin_hi_i
    && !transient_boost_o && d.st == bcsf_pkg::BCSF_RUN |=> transient_boost_o)
    else $error("boost missing");
  boost_len_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    transient_boost_o && switching && q.bst_cnt != 16'(BOOST_LEN - 1)
    |=> transient_boost_o || !switching)
    else $error("boost too short");
  soft_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.st == bcsf_pkg::BCSF_OFF && !supply_ok_i |=> !soft_start_o)
    else $error("soft start without supplies");
  stop_dis_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && !channel_enable_i && d.st != bcsf_pkg::BCSF_LATCHED |=> discharge_o)
    else $error("no discharge on disable");
  release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.st == bcsf_pkg::BCSF_STOP && out_low_i |=> !discharge_o)
    else $error("discharge not released");
  latch_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fault_latched_o && $stable(channel_enable_i) |=> fault_latched_o)
    else $error("latch cleared without toggle");
  latch_cnt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(fault_latched_o) |-> $past(q.flt_cnt) == 5'h0F)
    else $error("latched at wrong count");

  // Clock rates and pulse timing
  boost_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(transient_boost_o) && switching |-> $past(q.bst_cnt) == 16'(BOOST_LEN - 1))
    else $error("boost ended at wrong count");
  boost_fast_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    transient_boost_o && switching && !skipping |-> start_pulse == fst_tick)
    else $error("boost not on fast clock");
  normal_rate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !transient_boost_o && switching && !skipping |-> start_pulse == nrm_tick)
    else $error("pulse off normal clock");
  fast_ratio_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    nrm_tick |-> fst_tick)
    else $error("fast clock not aligned");
  fast_period_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fst_tick |-> ##FAST_DIV fst_tick)
    else $error("fast clock period wrong");
  skip_fire_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    skip_due_s ##0 (!current_limit_i && d.st == bcsf_pkg::BCSF_RUN) |=> hs_gate_o)
    else $error("skip pulse late");
  skip_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    skipping && !q.skip_pend && !hs_gate_o |=> !hs_gate_o)
    else $error("skip pulse without demand");
  skip_ls_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    skipping |=> !ls_gate_o)
    else $error("low side on while skipping");
  soft_ccm_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_start_o && $past(soft_start_o) |-> hs_gate_o ^ ls_gate_o)
    else $error("soft start not continuous");
  limit_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    start_pulse && current_limit_i |=> !hs_gate_o)
    else $error("pulse started into limit");
  boost_ccm_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    skipping && !transient_boost_o |=> !transient_boost_o)
    else $error("boost rose while skipping");
  boost_soft_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_start_o |=> !transient_boost_o)
    else $error("boost during soft start");

  // Sequencing
  soft_entry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(soft_start_o) |-> $past(supply_ok_i) && $past(out_low_i) && $past(channel_enable_i))
    else $error("soft start entered early");
  dis_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    discharge_o && !fault_latched_o && !out_low_i |=> discharge_o)
    else $error("discharge dropped early");
  restart_dis_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.st == bcsf_pkg::BCSF_OFF && en_rise && supply_ok_i && !out_low_i
    |=> discharge_o && !soft_start_o)
    else $error("restart skipped discharge");
  uv_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && uv_fault_i && d.st != bcsf_pkg::BCSF_LATCHED |=> discharge_o)
    else $error("no discharge on undervoltage");
  off_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !switching |=> !hs_gate_o && !ls_gate_o)
    else $error("gates driven while stopped");

  // Fault timer and latch
  tmr_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && !current_limit_i && !q.limited |=> q.flt_cnt == 5'h00)
    else $error("fault timer not cleared");
  tmr_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && current_limit_i && nrm_tick |=> q.flt_cnt == $past(q.flt_cnt) + 5'h01)
    else $error("fault timer missed a tick");
  tmr_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && current_limit_i && !nrm_tick |=> $stable(q.flt_cnt))
    else $error("fault timer moved off tick");
  latch_cut_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    switching && q.flt_cnt == 5'h0F && nrm_tick && current_limit_i |=> fault_latched_o)
    else $error("latch-off missing");
  latch_exit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fault_latched_o && !$stable(channel_enable_i) |=> !fault_latched_o)
    else $error("latch kept after toggle");
endmodule

// [verif/bcsf_stage_model.sv]
// Power stage and output capacitor model feeding the output-low comparator
module bcsf_stage_model (
  input  wire logic mclk_i,      // Clock
  input  wire logic hs_gate_i,   // High-side drive
  input  wire logic discharge_i, // Discharge switch closed
  output logic      out_low_o    // Output below 0.3 V
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] level_q = 4'h0;
  // Charge survives a reset, as a real capacitor does
  always_ff @(posedge mclk_i) begin
    if (hs_gate_i && level_q != 4'hF) begin
      level_q <= level_q + 4'h1;
    end else if (discharge_i && level_q != 4'h0) begin
      level_q <= level_q - 4'h1;
    end
  end
  assign out_low_o = (level_q < 4'h2);
endmodule

// [verif/bcsf_channel_tb.sv]
// Self-checking bench for the channel sequencer
module bcsf_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_i = 1'b1, en = 1'b0, sup = 1'b0, comp = 1'b0, thr_hi = 1'b0;
  logic lim = 1'b0, ss_done = 1'b0, out_low, hs, ls, flt, dis, ss, boost, latched;
  logic skip_n = 1'b0, skip_dem = 1'b0, ind_neg = 1'b0, uv = 1'b0;
  int   errors = 0, n_compared = 0, n;
  logic [1:0] rows [2] = '{2'b11, 2'b00}; // supply at rise, expected soft-start
  always #5 mclk_i = ~mclk_i;
  bcsf_channel #(.FSW_DIV(40), .ON_TIME(4)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .channel_enable_i(en), .supply_ok_i(sup), .out_low_i(out_low), .comp_over_thr_i(comp),
    .boost_thr_pin_hi_i(thr_hi), .skip_select_n_i(skip_n), .skip_demand_i(skip_dem),
    .ind_negative_i(ind_neg), .current_limit_i(lim), .ss_done_i(ss_done), .uv_fault_i(uv),
    .hs_gate_o(hs), .ls_gate_o(ls), .gate_float_o(flt), .discharge_o(dis),
    .soft_start_o(ss), .transient_boost_o(boost), .fault_latched_o(latched));
  bcsf_stage_model stage (.mclk_i(mclk_i), .hs_gate_i(hs), .discharge_i(dis),
    .out_low_o(out_low));
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return ss;
      1: return hs;
      2: return boost;
      default: return latched;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic lvl, input int max);
    n = 0;
    while (pick(k) !== lvl && n < max) begin
      cyc(1);
      n++;
    end
    if (pick(k) !== lvl) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, pick(k), lvl);
      final_report();
    end
  endtask
  initial begin
    cyc(16);
    rst_i = 1'b0;
    chk({hs, ls, flt, dis, ss, boost, latched}, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      sup = rows[i][1];
      en = 1'b1;
      cyc(1);
      sup = 1'b1;
      cyc(3);
      chk(ss, rows[i][0]);
      en = 1'b0;
      cyc(20);
    end
    $display("test enable rows done");
    en = 1'b1;
    wait_for(0, 1'b1, 5);
    ss_done = 1'b1;
    wait_for(1, 1'b1, 100);
    cyc(200);
    chk(out_low, 1'b0);
    thr_hi = 1'b1;
    comp = 1'b1;
    cyc(5);
    chk(boost, 1'b0);
    comp = 1'b0;
    thr_hi = 1'b0;
    cyc(2);
    comp = 1'b1;
    wait_for(2, 1'b1, 5);
    comp = 1'b0;
    wait_for(2, 1'b0, 60);
    chk(16'(n), 16'h0028);
    $display("test boost done");
    skip_n = 1'b1;
    ind_neg = 1'b1;
    cyc(45);
    chk({hs, ls}, 16'h0000);
    skip_dem = 1'b1;
    cyc(1);
    skip_dem = 1'b0;
    wait_for(1, 1'b1, 9);
    $display("test skip done");
    skip_n = 1'b0;
    ind_neg = 1'b0;
    lim = 1'b1;
    cyc(3);
    chk(hs, 1'b0);
    cyc(100);
    lim = 1'b0;
    cyc(200);
    chk(latched, 1'b0);
    $display("test short limit done");
    ss_done = 1'b0;
    skip_n = 1'b1;
    ind_neg = 1'b1;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(3);
    chk({dis, ss}, 16'h0002);
    wait_for(0, 1'b1, 60);
    chk(out_low, 1'b1);
    cyc(1);
    chk(hs ^ ls, 1'b1);
    ss_done = 1'b1;
    skip_n = 1'b0;
    ind_neg = 1'b0;
    $display("test restart done");
    lim = 1'b1;
    wait_for(3, 1'b1, 900);
    chk(n > 500, 1'b1);
    chk({flt, hs, ls}, 16'h0004);
    comp = 1'b1;
    cyc(5);
    chk(boost, 1'b0);
    chk(dis, !out_low);
    lim = 1'b0;
    comp = 1'b0;
    en = 1'b0;
    cyc(30);
    en = 1'b1;
    cyc(3);
    chk({latched, flt}, 16'h0000);
    $display("test latch-off done");
    uv = 1'b1;
    cyc(1);
    chk({dis, ss, latched}, 16'h0004);
    uv = 1'b0;
    cyc(6);
    chk(dis, 1'b0);
    $display("test undervoltage done");
    final_report();
  end
endmodule
